// ### rtl/rse_pkg.sv
/*
 * Constants, types and decode helpers for the rotate and power-down executor.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package rse_pkg;

    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0] RSE_ADDR_INSTR = 8'h00;
    localparam logic [7:0] RSE_ADDR_ACC = 8'h04;
    localparam logic [7:0] RSE_ADDR_STATUS = 8'h08;
    localparam logic [7:0] RSE_ADDR_WDOG = 8'h0C;
    localparam logic [7:0] RSE_ADDR_WAKE = 8'h10;
    localparam logic [7:0] RSE_ADDR_MADDR = 8'h14;
    localparam logic [7:0] RSE_ADDR_MDATA = 8'h18;

    // ==========================================
    // Status field positions
    localparam int RSE_ST_CARRY = 0;
    localparam int RSE_ST_DCARRY = 1;
    localparam int RSE_ST_ZERO = 2;
    localparam int RSE_ST_PD = 3;
    localparam int RSE_ST_TO = 4;
    localparam int RSE_ST_ASLEEP = 5;
    localparam int RSE_ST_W = 6;
    localparam logic [4:0] RSE_STATUS_RST = 5'h18;

    // ==========================================
    // Instruction encodings
    localparam logic [5:0] RSE_OP_RRF = 6'h0C;
    localparam logic [5:0] RSE_OP_RLF = 6'h0D;
    localparam logic [13:0] RSE_CODE_SLEEP = 14'h0063;
    localparam int RSE_DEST_BIT = 7;

    // ==========================================
    // Watchdog
    localparam logic [7:0] RSE_WDOG_PRESC_MAX = 8'hFF;
    localparam logic [7:0] RSE_WDOG_RST = 8'h00;

    typedef enum logic [1:0] {
        RSE_IDLE,
        RSE_LOAD,
        RSE_EXEC
    } rse_state_t;

    function automatic logic rse_is_rrf(input logic [13:0] ir);
        return ir[13:8] == RSE_OP_RRF;
    endfunction

    function automatic logic rse_is_rlf(input logic [13:0] ir);
        return ir[13:8] == RSE_OP_RLF;
    endfunction

endpackage

// ### rtl/rse_data_mem.sv
/*
 * 128 x 8 data memory, one write port and one registered read port.
 * Assumes a single clock; read data lag the address by one cycle.
 */
`timescale 1ns/100ps
module rse_data_mem (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [6:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [128];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-before-read is not bypassed; the caller waits a cycle
    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule // rse_data_mem

// ### rtl/rse_exec.sv
/*
 * Rotate-through-carry and power-down executor behind an AHB-Lite slave.
 * Assumes one AHB-Lite master, single word transfers, hclk at 100 MHz.
 */
`timescale 1ns/100ps
// Overview of operation
// [RQ1] Opcode 001100 d fffffff rotates the register right through carry.
// [RQ2] Opcode 001101 d fffffff rotates the register left through carry.
// [RQ3] Destination bit 0 writes accumulator; 1 writes back the register.
// [RQ4] Register operand is seven bits, locations 0 to 127.
// [RQ5] Rotates change only carry; zero and digit carry hold.
// [RQ6] Power-down clears the watchdog counter and its prescaler.
// [RQ7] Power-down clears the power-down flag and sets the expiry flag.
// [RQ8] Code 00 0000 0110 0011 enters power-down with oscillator halted.
// [RQ9] Old carry enters vacated end bit; shifted-out bit becomes carry.
module rse_exec
    import rse_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core status
    output logic osc_stop
);
    // ==========================================
    // Bus address phase capture
    logic dph_q, dph_wr_q, dph_wait_q;
    logic [7:0] dph_addr_q;
    rse_state_t state_q;
    logic [13:0] ir_q;
    logic [7:0] acc_q, wdog_q, presc_q;
    logic [4:0] status_q;
    logic asleep_q;
    logic [6:0] maddr_q;
    logic mem_we;
    logic [6:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata, mem_rdata_q, rot;
    logic rot_c, busy, dph_done, wr_done, is_rrf;

    assign busy = state_q != RSE_IDLE;
    assign hreadyout = !(dph_q && (busy || (!dph_wr_q && dph_addr_q == RSE_ADDR_MDATA
        && !dph_wait_q)));
    assign hresp = 1'b0;
    assign dph_done = dph_q && hreadyout;
    assign wr_done = dph_done && dph_wr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= 1'b0;
            dph_wr_q <= 1'b0;
            dph_addr_q <= 8'h00;
        end else if (hready) begin
            dph_q <= hsel && htrans[1];
            dph_wr_q <= hwrite;
            dph_addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // Memory reads need one extra cycle for registered data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wait_q <= 1'b0;
        end else begin
            dph_wait_q <= dph_q && !hreadyout && !busy;
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (dph_q && !dph_wr_q) begin
            case (dph_addr_q)
                RSE_ADDR_INSTR: hrdata = {18'h0_0000, ir_q};
                RSE_ADDR_ACC: hrdata = {24'h00_0000, acc_q};
                RSE_ADDR_STATUS: hrdata = {26'h000_0000, asleep_q, status_q};
                RSE_ADDR_WDOG: hrdata = {24'h00_0000, wdog_q};
                RSE_ADDR_MADDR: hrdata = {25'h000_0000, maddr_q};
                RSE_ADDR_MDATA: hrdata = {24'h00_0000, mem_rdata_q};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // Instruction sequencing
    logic take_instr, take_sleep, take_rot;
    assign take_instr = wr_done && dph_addr_q == RSE_ADDR_INSTR && !asleep_q;
    // [RQ8] power-down decode
    assign take_sleep = take_instr && hwdata[13:0] == RSE_CODE_SLEEP;
    // [RQ1] [RQ2] rotate decode
    assign take_rot = take_instr && (rse_is_rrf(hwdata[13:0]) || rse_is_rlf(hwdata[13:0]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= RSE_IDLE;
        end else begin
            case (state_q)
                RSE_IDLE: state_q <= take_rot ? RSE_LOAD : RSE_IDLE;
                RSE_LOAD: state_q <= RSE_EXEC;
                RSE_EXEC: state_q <= RSE_IDLE;
                default: state_q <= RSE_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_q <= 14'h0000;
        end else if (take_instr) begin
            ir_q <= hwdata[13:0];
        end
    end

    // ==========================================
    // Rotate datapath
    assign is_rrf = rse_is_rrf(ir_q);
    // [RQ9] carry in at vacated end, carry out from shifted bit
    assign rot = is_rrf ? {status_q[RSE_ST_CARRY], mem_rdata_q[7:1]}
        : {mem_rdata_q[6:0], status_q[RSE_ST_CARRY]};
    assign rot_c = is_rrf ? mem_rdata_q[0] : mem_rdata_q[7];

    // [RQ4] seven-bit operand field addresses the whole memory
    assign mem_raddr = busy ? ir_q[6:0] : maddr_q;
    // [RQ3] destination bit selects write-back
    assign mem_we = (state_q == RSE_EXEC && ir_q[RSE_DEST_BIT])
        || (wr_done && dph_addr_q == RSE_ADDR_MDATA);
    assign mem_waddr = busy ? ir_q[6:0] : maddr_q;
    assign mem_wdata = busy ? rot : hwdata[7:0];

    rse_data_mem u_mem (
        .clk(hclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata_q)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 8'h00;
        end else if (state_q == RSE_EXEC && !ir_q[RSE_DEST_BIT]) begin
            // [RQ3] destination 0 lands in accumulator
            acc_q <= rot;
        end else if (wr_done && dph_addr_q == RSE_ADDR_ACC) begin
            acc_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            maddr_q <= 7'h00;
        end else if (wr_done && dph_addr_q == RSE_ADDR_MADDR) begin
            maddr_q <= hwdata[6:0];
        end
    end

    // ==========================================
    // Status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= RSE_STATUS_RST;
        end else if (state_q == RSE_EXEC) begin
            // [RQ5] only carry changes on rotate
            status_q[RSE_ST_CARRY] <= rot_c;
        end else if (take_sleep) begin
            // [RQ7] power-down flag low, expiry flag high
            status_q[RSE_ST_PD] <= 1'b0;
            status_q[RSE_ST_TO] <= 1'b1;
        end else if (wr_done && dph_addr_q == RSE_ADDR_STATUS) begin
            status_q <= hwdata[4:0];
        end
    end

    // Oscillator stays halted until software wakes the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            asleep_q <= 1'b0;
        end else if (take_sleep) begin
            // [RQ8] enter low-power state
            asleep_q <= 1'b1;
        end else if (wr_done && dph_addr_q == RSE_ADDR_WAKE && hwdata[0]) begin
            asleep_q <= 1'b0;
        end
    end
    assign osc_stop = asleep_q;

    // ==========================================
    // Watchdog counter and prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= RSE_WDOG_RST;
            wdog_q <= RSE_WDOG_RST;
        end else if (take_sleep) begin
            // [RQ6] clear counter and prescaler
            presc_q <= RSE_WDOG_RST;
            wdog_q <= RSE_WDOG_RST;
        end else begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == RSE_WDOG_PRESC_MAX) begin
                wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    // ==========================================
    // Checks
    property p_rrf_acc;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == RSE_EXEC && is_rrf && !ir_q[RSE_DEST_BIT])
        |=> acc_q == {$past(status_q[RSE_ST_CARRY]), $past(mem_rdata_q[7:1])}
            && status_q[RSE_ST_CARRY] == $past(mem_rdata_q[0]);
    endproperty
    a_rrf_acc: assert property (p_rrf_acc) else $error("rotate right result wrong"); // [RQ1]

    property p_rlf_carry;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == RSE_EXEC && !is_rrf)
        |=> status_q[RSE_ST_CARRY] == $past(mem_rdata_q[7]);
    endproperty
    a_rlf_carry: assert property (p_rlf_carry) else $error("rotate left carry wrong"); // [RQ2]

    property p_dest_acc;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == RSE_EXEC && !ir_q[RSE_DEST_BIT]) |-> !mem_we;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("register written for dest 0"); // [RQ3]

    property p_dest_reg;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == RSE_EXEC && ir_q[RSE_DEST_BIT]) |-> mem_we && mem_waddr == ir_q[6:0]
            ##1 $stable(acc_q);
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("write-back to register wrong"); // [RQ4]

    property p_flags_hold;
        @(posedge hclk) disable iff (!hresetn)
        take_rot |-> ##2 (state_q == RSE_EXEC) ##1 ($stable(status_q[RSE_ST_ZERO])
            && $stable(status_q[RSE_ST_DCARRY]));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("rotate touched zero or dc"); // [RQ5]

    property p_sleep_wdog;
        @(posedge hclk) disable iff (!hresetn)
        take_sleep |=> wdog_q == 8'h00 && presc_q == 8'h00;
    endproperty
    a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared"); // [RQ6]

    property p_sleep_flags;
        @(posedge hclk) disable iff (!hresetn)
        take_sleep |=> !status_q[RSE_ST_PD] && status_q[RSE_ST_TO];
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("power flags wrong"); // [RQ7]

    property p_sleep_osc;
        @(posedge hclk) disable iff (!hresetn)
        take_sleep |=> osc_stop [*2];
    endproperty
    a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator not halted"); // [RQ8]

    property p_rot_carry_in;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == RSE_EXEC) |-> (is_rrf ? rot[7] : rot[0]) == status_q[RSE_ST_CARRY];
    endproperty
    a_rot_carry_in: assert property (p_rot_carry_in) else $error("carry not shifted in"); // [RQ9]
endmodule // rse_exec

// ### dv/rse_ahb_master.sv
/*
 * Bus master model that stands on the far side of the executor.
 * Assumes one slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/100ps
module rse_ahb_master (
    // Clock
    input wire logic hclk,
    // Master outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Slave answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // ==========================================
    // Single word transfer, called just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        // Read cycles carry a changing pattern, never stale data
        hwdata <= wr ? wd : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
endmodule // rse_ahb_master

// ### dv/tb_rotate_and_sleep_execute.sv
/*
 * Self-checking bench for the rotate and power-down executor.
 * Assumes the bus master model and a 100 MHz hclk.
 */
`timescale 1ns/100ps
module tb_rotate_and_sleep_execute;
    import rse_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hreadyout, hresp, osc_stop;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int num_errors = 0;
    int n_tests = 0;
    int f, v, a, cy, dz, d, op, res, nc;

    always #5 hclk = ~hclk;
    assign hready = hreadyout;

    rse_exec rse_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_stop(osc_stop));
    rse_ahb_master rse_ahb_master_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata));

    // ==========================================
    // Compare, bus and closing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
        rse_ahb_master_inst.xfer(1'b1, ad, dat, rd);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        rse_ahb_master_inst.xfer(1'b0, ad, 32'h0000_0000, rd);
        check(rd, exp);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Run is about 1600 cycles; allow several times that
    initial begin
        #200_000;
        num_errors++;
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(62));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(RSE_ADDR_STATUS, 32'h0000_0018);
        rdc(RSE_ADDR_ACC, 32'h0000_0000);
        rdc(8'h1C, 32'h0000_0000);
        $display("test reset done");
        // Boundaries 0 and 127 first, then random operands
        for (int i = 0; i < 40; i++) begin
            f = (i == 0) ? 0 : (i == 1) ? 127 : $urandom_range(127);
            v = $urandom_range(255);
            a = $urandom_range(255);
            cy = $urandom_range(1);
            dz = $urandom_range(3);
            d = $urandom_range(1);
            op = $urandom_range(1);
            wr(RSE_ADDR_MADDR, f);
            wr(RSE_ADDR_MDATA, v);
            wr(RSE_ADDR_ACC, a);
            wr(RSE_ADDR_STATUS, 32'h18 | (dz << 1) | cy);
            wr(RSE_ADDR_INSTR, {18'h0_0000, (op ? RSE_OP_RLF : RSE_OP_RRF), d[0], f[6:0]});
            res = op ? (((v << 1) | cy) & 255) : ((v >> 1) | (cy << 7));
            nc = op ? (v >> 7) : (v & 1);
            rdc(RSE_ADDR_ACC, d ? a : res);
            rdc(RSE_ADDR_MDATA, d ? res : v);
            rdc(RSE_ADDR_STATUS, 32'h18 | (dz << 1) | nc);
        end
        $display("test rotate done");
        repeat (600) @(posedge hclk);
        wr(RSE_ADDR_INSTR, 32'h0000_0063);
        #1;
        check(osc_stop, 32'h0000_0001);
        rdc(RSE_ADDR_STATUS, 32'h30 | (dz << 1) | nc);
        // A prescaler left running would wrap within this wait
        repeat (240) @(posedge hclk);
        rdc(RSE_ADDR_WDOG, 32'h0000_0000);
        wr(RSE_ADDR_INSTR, 32'h0000_0D80);
        rdc(RSE_ADDR_INSTR, 32'h0000_0063);
        wr(RSE_ADDR_WAKE, 32'h0000_0001);
        #1;
        check(osc_stop, 32'h0000_0000);
        $display("test sleep done");
        finish_test();
    end
endmodule // tb_rotate_and_sleep_execute
